/* pkg/limit_cmp_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LIMIT_CMP_REGS_SVH
`define LIMIT_CMP_REGS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_HIGH 4'h1
`define ADDR_LOW 4'h2
`define ADDR_HYST 4'h3
`define ADDR_OFFSET 4'h4
`define ADDR_ZERO_BAND 4'h5
`define ADDR_MOTION_BAND 4'h6
`define ADDR_MOTION_DELAY 4'h7
`define ADDR_STATUS 4'h8
`define ADDR_IRQ_STAT 4'h9
`define ADDR_IRQ_MASK 4'hA
`define ADDR_DISPLAY 4'hB
`define ADDR_CAP_IN 4'hC
`define ADDR_CAP_OUT 4'hD
`define ADDR_LIMIT_PAIR 4'hE
`define LIMIT_ORDER_ERROR_CODE 8'h08
`define CTRL_RESET 32'h0000_0000
`define HIGH_RESET 32'h0000_03E8
`define LOW_RESET 32'hFFFF_FC18
`define MOTION_WINDOW_MS 100
`define MS_PER_S 1000
`define CLOCK_HZ 250000000
`define MOTION_WINDOW_CYCLES ((`CLOCK_HZ / `MS_PER_S) * `MOTION_WINDOW_MS)
`define IRQ_HI_BIT 0
`define IRQ_LO_BIT 1
`define IRQ_ERR_BIT 2
`define IRQ_STABLE_BIT 3
`define IRQ_WIDTH 4
`endif

/* pkg/limit_cmp_pkg.sv */
// Types for the limit comparator
package limit_cmp_pkg;
   typedef enum logic [1:0] {
      gate_always = 2'h0,
      gate_stable = 2'h1,
      gate_nonzero = 2'h2,
      gate_both = 2'h3
   } gate_mode_t;
   typedef enum logic [1:0] {
      bus_idle = 2'h0,
      bus_answer = 2'h1
   } bus_state_t;
endpackage

/* hw/limit_cmp.sv */
// Limit comparator with offset, hysteresis, gating and capacity scaling
// Operation
// - High relay on when indication value strictly above high limit.
// - Low relay on when indication value strictly below low limit.
// - High and low limits are held as signed values.
// - Refuse limit pair with high not above low; show limit-order error code.
// - Two-bit gate: 0 always, 1 stable, 2 off zero, 3 both.
// - High relay releases once value at or below high minus hysteresis.
// - Low relay releases once value at or above low plus hysteresis.
// - Displayed value is measured value minus programmed offset.
// - Capacity display decimals by decade: 1-4 three, 5-40 two, 50-400 one, 500 none.
// - Zero vicinity when absolute value lies within zero band.
// - Stable when samples stay within motion band of 100 ms earlier for delay.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`include "limit_cmp_regs.svh"
module limit_cmp
   import limit_cmp_pkg::*;
#(
   parameter int W = 24,
   parameter int MOTION_CYCLES = `MOTION_WINDOW_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] sample_value,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic high_relay,
   output logic low_relay,
   output logic signed [W-1:0] display_value,
   output logic irq
);
   logic [1:0] gate_mode_r;
   logic signed [W-1:0] high_limit_r;
   logic signed [W-1:0] low_limit_r;
   logic [W-1:0] hyst_r;
   logic signed [W-1:0] offset_r;
   logic [W-1:0] zero_band_r;
   logic [W-1:0] motion_band_r;
   logic [15:0] motion_delay_r;
   logic [15:0] cap_in_r;
   logic [15:0] cap_mant_r;
   logic [1:0] cap_dec_r;
   logic cap_kilo_r;
   logic limit_err_r;
   logic signed [W-1:0] pend_r;
   logic [`IRQ_WIDTH-1:0] irq_stat_r;
   logic [`IRQ_WIDTH-1:0] irq_mask_r;
   logic stable_r;
   logic zero_near_r;
   logic [15:0] stable_cnt_r;
   logic [31:0] window_cnt_r;
   logic signed [W-1:0] ref_value_r;
   logic signed [W-1:0] last_value_r;
   logic ref_valid_r;
   bus_state_t bus_state_r;
   logic hi_set_ev;
   logic lo_set_ev;
   logic stable_ev;
   logic err_ev;
   logic bus_take;
   logic signed [W:0] corrected;
   logic signed [W:0] abs_val;
   logic signed [W:0] diff;
   logic signed [W:0] abs_diff;
   logic gate_open;
   logic hi_nxt;
   logic lo_nxt;
   logic signed [W-1:0] wr_value;
   logic wr_commit;
   logic window_end;
   logic in_band;
   logic zero_now;
   logic signed [W:0] high_ext;
   logic signed [W:0] low_ext;
   logic signed [W:0] hyst_ext;
   logic signed [W+1:0] hi_release;
   logic signed [W+1:0] lo_release;

   assign bus_take = (avs_read | avs_write) & (bus_state_r == bus_idle);
   // Writes land at the answer edge, while waitrequest is low
   assign wr_commit = avs_write & (bus_state_r == bus_answer);
   assign wr_value = avs_writedata[W-1:0];
   assign corrected = {sample_value[W-1], sample_value} - {offset_r[W-1], offset_r};
   assign abs_val = corrected[W] ? -corrected : corrected;
   assign zero_now = (abs_val <= {1'b0, zero_band_r});
   // Motion compares held samples; the value line is only valid with sample_valid
   assign diff = {last_value_r[W-1], last_value_r} - {ref_value_r[W-1], ref_value_r};
   assign abs_diff = diff[W] ? -diff : diff;
   assign window_end = (window_cnt_r >= 32'(MOTION_CYCLES - 1));
   assign in_band = (abs_diff <= {1'b0, motion_band_r});
   // Signed limit operands, one guard bit for the hysteresis sums
   assign high_ext = {high_limit_r[W-1], high_limit_r};
   assign low_ext = {low_limit_r[W-1], low_limit_r};
   assign hyst_ext = {1'b0, hyst_r};
   assign hi_release = high_ext - hyst_ext;
   assign lo_release = low_ext + hyst_ext;

   // Gate decode
   always_comb begin
      unique case (gate_mode_t'(gate_mode_r))
         gate_always: gate_open = 1'b1;
         gate_stable: gate_open = stable_r;
         gate_nonzero: gate_open = ~zero_now;
         gate_both: gate_open = stable_r & ~zero_now;
      endcase
   end

   // Relay decision with hysteresis
   always_comb begin
      hi_nxt = high_relay;
      lo_nxt = low_relay;
      if (!gate_open) begin
         hi_nxt = 1'b0;
         lo_nxt = 1'b0;
      end else begin
         if (corrected > high_ext) begin
            hi_nxt = 1'b1;
         end else if (corrected <= hi_release) begin
            hi_nxt = 1'b0;
         end
         if (corrected < low_ext) begin
            lo_nxt = 1'b1;
         end else if (corrected >= lo_release) begin
            lo_nxt = 1'b0;
         end
      end
   end

   assign hi_set_ev = sample_valid & hi_nxt & ~high_relay;
   assign lo_set_ev = sample_valid & lo_nxt & ~low_relay;

   // Relay outputs and display value
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         high_relay <= 1'b0;
         low_relay <= 1'b0;
         display_value <= '0;
      end else if (sample_valid) begin
         high_relay <= hi_nxt;
         low_relay <= lo_nxt;
         display_value <= corrected[W-1:0];
      end
   end

   // Zero vicinity flag
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         zero_near_r <= 1'b0;
      end else if (sample_valid) begin
         zero_near_r <= zero_now;
      end
   end

   // Motion detect: compare to reference taken each 100 ms window
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         window_cnt_r <= '0;
         ref_value_r <= '0;
         ref_valid_r <= 1'b0;
         stable_cnt_r <= '0;
         stable_r <= 1'b0;
         last_value_r <= '0;
      end else begin
         if (sample_valid) begin
            last_value_r <= sample_value;
         end
         if (window_end) begin
            window_cnt_r <= '0;
            ref_value_r <= last_value_r;
            ref_valid_r <= 1'b1;
            if (ref_valid_r && in_band) begin
               if (stable_cnt_r >= motion_delay_r) begin
                  stable_r <= 1'b1;
               end else begin
                  stable_cnt_r <= stable_cnt_r + 16'h0001;
               end
            end else begin
               stable_cnt_r <= '0;
               stable_r <= 1'b0;
            end
         end else begin
            window_cnt_r <= window_cnt_r + 32'h0000_0001;
         end
      end
   end

   // Fires once, at the window that turns the stable flag on
   assign stable_ev = window_end & ref_valid_r & in_band & (stable_cnt_r >= motion_delay_r) & ~stable_r;
   assign err_ev = wr_commit & (avs_address == `ADDR_LIMIT_PAIR)
      & ~($signed(avs_writedata[31:16]) > $signed(avs_writedata[15:0]));

   // Limit and setting registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gate_mode_r <= 2'h0;
         high_limit_r <= W'(signed'(`HIGH_RESET));
         low_limit_r <= W'(signed'(`LOW_RESET));
         hyst_r <= '0;
         offset_r <= '0;
         zero_band_r <= '0;
         motion_band_r <= '0;
         motion_delay_r <= '0;
         limit_err_r <= 1'b0;
         pend_r <= '0;
         irq_mask_r <= '0;
      end else if (wr_commit) begin
         unique case (avs_address)
            `ADDR_CTRL: gate_mode_r <= avs_writedata[1:0];
            `ADDR_HIGH: pend_r <= wr_value;
            `ADDR_LOW: begin
               if (pend_r > wr_value) begin
                  high_limit_r <= pend_r;
                  low_limit_r <= wr_value;
                  limit_err_r <= 1'b0;
               end else begin
                  limit_err_r <= 1'b1;
               end
            end
            `ADDR_LIMIT_PAIR: begin
               if (!err_ev) begin
                  high_limit_r <= W'($signed(avs_writedata[31:16]));
                  low_limit_r <= W'($signed(avs_writedata[15:0]));
                  limit_err_r <= 1'b0;
               end else begin
                  limit_err_r <= 1'b1;
               end
            end
            `ADDR_HYST: hyst_r <= wr_value;
            `ADDR_OFFSET: offset_r <= wr_value;
            `ADDR_ZERO_BAND: zero_band_r <= wr_value;
            `ADDR_MOTION_BAND: motion_band_r <= wr_value;
            `ADDR_MOTION_DELAY: motion_delay_r <= avs_writedata[15:0];
            `ADDR_IRQ_MASK: irq_mask_r <= avs_writedata[`IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // Capacity display scaling by decade
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cap_in_r <= '0;
         cap_mant_r <= '0;
         cap_dec_r <= 2'h0;
         cap_kilo_r <= 1'b0;
      end else if (wr_commit && avs_address == `ADDR_CAP_IN) begin
         cap_in_r <= avs_writedata[15:0];
         cap_kilo_r <= avs_writedata[16];
         cap_mant_r <= avs_writedata[15:0];
         if (avs_writedata[15:0] < 16'h0005) begin
            cap_dec_r <= 2'h3;
         end else if (avs_writedata[15:0] < 16'h0032) begin
            cap_dec_r <= 2'h2;
         end else if (avs_writedata[15:0] < 16'h01F4) begin
            cap_dec_r <= 2'h1;
         end else begin
            cap_dec_r <= 2'h0;
         end
      end
   end

   // Interrupt status, cleared by a read; a new event wins over the clear
   logic [`IRQ_WIDTH-1:0] ev_vec;
   assign ev_vec = {stable_ev, err_ev | (wr_commit & avs_address == `ADDR_LOW & ~(pend_r > wr_value)),
      lo_set_ev, hi_set_ev};
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= '0;
      end else if (bus_take && avs_read && avs_address == `ADDR_IRQ_STAT) begin
         irq_stat_r <= ev_vec;
      end else begin
         irq_stat_r <= irq_stat_r | ev_vec;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_r | ev_vec) & irq_mask_r);
      end
   end

   // Avalon slave: one wait cycle, answer on the second edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_state_r <= bus_idle;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         unique case (bus_state_r)
            bus_idle: begin
               if (bus_take) begin
                  bus_state_r <= bus_answer;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= '0;
                  if (avs_read) begin
                     unique case (avs_address)
                        `ADDR_CTRL: avs_readdata <= {30'h0, gate_mode_r};
                        `ADDR_HIGH: avs_readdata <= 32'(high_limit_r);
                        `ADDR_LOW: avs_readdata <= 32'(low_limit_r);
                        `ADDR_HYST: avs_readdata <= 32'(hyst_r);
                        `ADDR_OFFSET: avs_readdata <= 32'(offset_r);
                        `ADDR_ZERO_BAND: avs_readdata <= 32'(zero_band_r);
                        `ADDR_MOTION_BAND: avs_readdata <= 32'(motion_band_r);
                        `ADDR_MOTION_DELAY: avs_readdata <= {16'h0, motion_delay_r};
                        `ADDR_STATUS: avs_readdata <= {16'h0,
                           (limit_err_r ? `LIMIT_ORDER_ERROR_CODE : 8'h00),
                           3'h0, limit_err_r, zero_near_r, stable_r, low_relay, high_relay};
                        `ADDR_IRQ_STAT: avs_readdata <= {28'h0, irq_stat_r};
                        `ADDR_IRQ_MASK: avs_readdata <= {28'h0, irq_mask_r};
                        `ADDR_DISPLAY: avs_readdata <= 32'(display_value);
                        `ADDR_CAP_IN: avs_readdata <= {15'h0, cap_kilo_r, cap_in_r};
                        `ADDR_CAP_OUT: avs_readdata <= {13'h0, cap_kilo_r, cap_dec_r, cap_mant_r};
                        default: avs_readdata <= 32'h0000_0000;
                     endcase
                  end
               end
            end
            bus_answer: begin
               bus_state_r <= bus_idle;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_r <= bus_idle;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end
endmodule

/* test/meas_source.sv */
// Measurement path model feeding samples to the comparator
module meas_source #(
   parameter int W = 24
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic go,
   input wire logic signed [W-1:0] go_value,
   output logic sample_valid,
   output logic signed [W-1:0] sample_value
);
   timeunit 1ns;
   timeprecision 1ps;
   // Between samples the value line toggles
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sample_valid <= 1'b0;
         sample_value <= '0;
      end else begin
         sample_valid <= go;
         sample_value <= go ? go_value : ~sample_value;
      end
   end
endmodule

/* test/limit_cmp_asserts.sv */
// Port checker for the limit comparator
`include "limit_cmp_regs.svh"
module limit_cmp_asserts
   import limit_cmp_pkg::*;
#(
   parameter int W = 24,
   parameter int MOTION_CYCLES = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] sample_value,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic high_relay,
   input wire logic low_relay,
   input wire logic signed [W-1:0] display_value,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [W-1:0] offset_r;
   logic [3:0] mask_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Shadow of offset and mask writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         offset_r <= '0;
         mask_r <= '0;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == `ADDR_OFFSET) offset_r <= avs_writedata[W-1:0];
         if (avs_address == `ADDR_IRQ_MASK) mask_r <= avs_writedata[3:0];
      end
   end
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_quiet;
      !sample_valid;
   endsequence
   property p_disp_hold; s_quiet |=> $stable(display_value); endproperty
   a_disp_hold: assert property (p_disp_hold) else $error("display moved");
   property p_disp_calc; sample_valid |=> display_value == $past(sample_value) - $past(offset_r); endproperty
   a_disp_calc: assert property (p_disp_calc) else $error("display value wrong");
   property p_hi_hold; s_quiet |=> $stable(high_relay); endproperty
   a_hi_hold: assert property (p_hi_hold) else $error("high relay moved");
   property p_lo_hold; s_quiet |=> $stable(low_relay); endproperty
   a_lo_hold: assert property (p_lo_hold) else $error("low relay moved");
   property p_wait_answer; s_req |=> !avs_waitrequest; endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer too long");
   property p_unmapped; avs_read && avs_address == 4'hF && !avs_waitrequest |-> avs_readdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   property p_irq_mask; (mask_r == 4'h0) [*2] |=> !irq; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule
bind limit_cmp limit_cmp_asserts #(.W(W), .MOTION_CYCLES(MOTION_CYCLES)) chk_u (.clock, .rstn, .sample_valid,
   .sample_value, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
   .high_relay, .low_relay, .display_value, .irq);

/* test/testbench.sv */
// Testbench for the limit comparator
`include "limit_cmp_regs.svh"
module testbench
   import limit_cmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn, go, sample_valid, avs_read, avs_write, avs_waitrequest, high_relay, low_relay, irq;
   logic signed [23:0] go_value, sample_value, display_value;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   int fail_count, total_checks;
   always #2 clock = ~clock;
   meas_source src_u (.clock, .rstn, .go, .go_value, .sample_valid, .sample_value);
   limit_cmp #(.W(24), .MOTION_CYCLES(8)) dut_u (.clock, .rstn, .sample_valid, .sample_value, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .high_relay, .low_relay,
      .display_value, .irq);
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic rel(input logic h, input logic l);
      chk({30'h0, high_relay, low_relay}, {30'h0, h, l});
   endtask
   task automatic samp(input int v);
      @(posedge clock);
      go <= 1'b1;
      go_value <= 24'(v);
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic stream(input int n, input int a, input int b, input int c);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         go <= 1'b1;
         go_value <= 24'(i % 3 == 0 ? a : (i % 3 == 1 ? b : c));
      end
      @(posedge clock);
      go <= 1'b0;
   endtask
   task automatic t_reset();
      chk({29'h0, high_relay, low_relay, irq}, 32'h0);
      rd(`ADDR_CTRL, 32'hFFFF_FFFF, `CTRL_RESET);
      rd(`ADDR_HIGH, 32'hFFFF_FFFF, `HIGH_RESET);
      rd(`ADDR_LOW, 32'hFFFF_FFFF, `LOW_RESET);
      wr(4'hF, 32'h1234_5678);
      rd(4'hF, 32'hFFFF_FFFF, 32'h0);
   endtask
   task automatic t_limits();
      int tv[8] = '{1010, 1011, 1006, 1005, -990, -991, -986, -985};
      bit eh[8] = '{0, 1, 1, 0, 0, 0, 0, 0};
      bit el[8] = '{0, 0, 0, 0, 0, 1, 1, 0};
      wr(`ADDR_OFFSET, 32'hA);
      wr(`ADDR_HYST, 32'h5);
      for (int i = 0; i < 8; i++) begin
         samp(tv[i]);
         chk(32'(display_value), 32'(tv[i] - 10));
         rel(eh[i], el[i]);
      end
   endtask
   task automatic t_order();
      wr(`ADDR_HIGH, 32'hFFFF_FFCE);
      wr(`ADDR_LOW, 32'hFFFF_FF38);
      rd(`ADDR_HIGH, 32'hFFFF_FFFF, 32'hFFFF_FFCE);
      samp(-39);
      rel(1'b1, 1'b0);
      wr(`ADDR_IRQ_MASK, 32'h4);
      wr(`ADDR_HIGH, 32'h5);
      wr(`ADDR_LOW, 32'h5);
      rd(`ADDR_HIGH, 32'hFFFF_FFFF, 32'hFFFF_FFCE);
      rd(`ADDR_STATUS, 32'h0000_FF10, {16'h0, `LIMIT_ORDER_ERROR_CODE, 8'h10});
      chk({31'h0, irq}, 32'h1);
      rd(`ADDR_IRQ_STAT, 32'h4, 32'h4);
      repeat (2) @(posedge clock);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(`ADDR_IRQ_MASK, 32'h0);
      wr(`ADDR_LIMIT_PAIR, 32'h000A_FFF6);
      rd(`ADDR_HIGH, 32'hFFFF_FFFF, 32'hA);
      rd(`ADDR_LOW, 32'hFFFF_FFFF, 32'hFFFF_FFF6);
   endtask
   task automatic t_gate();
      wr(`ADDR_ZERO_BAND, 32'h14);
      wr(`ADDR_MOTION_BAND, 32'h2);
      wr(`ADDR_MOTION_DELAY, 32'h1);
      wr(`ADDR_CTRL, {30'h0, gate_nonzero});
      samp(25);
      rel(1'b0, 1'b0);
      samp(45);
      rel(1'b1, 1'b0);
      wr(`ADDR_CTRL, {30'h0, gate_always});
      samp(25);
      rel(1'b1, 1'b0);
      wr(`ADDR_CTRL, {30'h0, gate_stable});
      stream(40, 25, 500, 900);
      samp(45);
      rel(1'b0, 1'b0);
      rd(`ADDR_STATUS, 32'h4, 32'h0);
      stream(80, 45, 45, 45);
      rd(`ADDR_STATUS, 32'h4, 32'h4);
      samp(45);
      rel(1'b1, 1'b0);
      wr(`ADDR_CTRL, {30'h0, gate_both});
      samp(45);
      rel(1'b1, 1'b0);
      samp(25);
      rel(1'b0, 1'b0);
   endtask
   task automatic t_cap();
      logic [31:0] ci[9] = '{32'h1, 32'h4, 32'h5, 32'h28, 32'h32, 32'h190, 32'h1F4, 32'h1_0001, 32'h1_0005};
      logic [1:0] dd[9] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2};
      for (int i = 0; i < 9; i++) begin
         wr(`ADDR_CAP_IN, ci[i]);
         rd(`ADDR_CAP_OUT, 32'h0007_FFFF, {13'h0, ci[i][16], dd[i], ci[i][15:0]});
      end
   endtask
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      go = 1'b0;
      go_value = '0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      fail_count = 0;
      total_checks = 0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_limits();
      t_order();
      t_gate();
      t_cap();
      report_and_stop();
   end
endmodule
